// file: include/rail_seq_pkg.sv
// Constants, field layout and state types of the rail sequencer.
// Assumes a 40 MHz system clock.
package rail_seq_pkg;
	// ----------------------------------------------------------
	// Timing
	// ----------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int FILT_TIME_US  = 300;
	localparam int LOCK_TIME_MS  = 200;
	localparam int SEQ_STEP_US   = 100;
	localparam int HICCUP_MS     = 10;
	localparam int FILT_CYC = (FILT_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int LOCK_CYC = (LOCK_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SEQ_STEP_CYC = (SEQ_STEP_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int HICCUP_CYC = (HICCUP_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W = 24;
	// ----------------------------------------------------------
	// Register map
	// ----------------------------------------------------------
	localparam logic [7:0] ADDR_SPREAD = 8'h7A;
	localparam logic [7:0] ADDR_LIN    = 8'h87;
	localparam logic [7:0] ADDR_CTRL   = 8'h90;
	localparam logic [7:0] ADDR_STATUS = 8'h91;
	localparam int LIN_HICCUP_BIT = 2;
	localparam int CTRL_PHASE_BIT = 0;
	localparam int CTRL_DLY_LSB   = 4;
	localparam logic [2:0] SPREAD_RST = 3'h0;
	localparam logic [3:0] DLY_RST    = 4'h0;
	// ----------------------------------------------------------
	// Switching clock
	// ----------------------------------------------------------
	localparam logic [15:0] NCO_CENTER  = 16'hE14;
	localparam logic [15:0] NCO_STEP    = 16'h9;
	localparam logic [15:0] NCO_BASE    = NCO_CENTER - 16'h10 * NCO_STEP;
	localparam logic [15:0] NCO_TOP     = NCO_BASE + 16'h1F * NCO_STEP;
	localparam logic [4:0]  FREQ_CENTER = 5'h10;
	localparam logic [4:0]  FREQ_MAX    = 5'h1F;
	localparam logic [15:0] LFSR_SEED   = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS   = 16'hB400;
	localparam logic [2:0] SS_OFF    = 3'h0;
	localparam logic [2:0] SS_SLOPE  = 3'h1;
	localparam logic [2:0] SS_RAND8  = 3'h2;
	localparam logic [2:0] SS_RAND32 = 3'h3;
	localparam logic [2:0] SS_TRI    = 3'h4;
	localparam logic [2:0] SS_FIX4   = 3'h5;
	localparam logic [2:0] SS_FIX8   = 3'h6;
	localparam logic [2:0] SS_FIX24  = 3'h7;
	// Dwell loads hold the dwell minus one
	localparam logic [4:0] DW_UP_M1  = 5'h2;
	localparam logic [4:0] DW_DN_M1  = 5'h5;
	localparam logic [4:0] DW_4_M1   = 5'h3;
	localparam logic [4:0] DW_8_M1   = 5'h7;
	localparam logic [4:0] DW_24_M1  = 5'h17;
	// ----------------------------------------------------------
	// Inputs and states
	// ----------------------------------------------------------
	localparam int IN_STBY = 0;
	localparam int IN_ON   = 1;
	localparam int IN_LOW  = 2;
	localparam int IN_SUP  = 3;
	localparam int IN_POR  = 4;
	localparam int IN_INIT = 5;
	localparam int IN_LOC  = 6;
	localparam int IN_POC  = 7;
	localparam int IN_POV  = 8;
	localparam int N_IN    = 9;
	localparam logic [1:0] LVL_OFF  = 2'h0;
	localparam logic [1:0] LVL_STBY = 2'h1;
	localparam logic [1:0] LVL_ON   = 2'h2;
	typedef enum logic [4:0] {
		M_OFF  = 5'h01,
		M_STBY = 5'h02,
		M_ON   = 5'h04,
		M_DOWN = 5'h08,
		M_HOLD = 5'h10
	} main_state_t;
	typedef enum logic [4:0] {
		L_OFF  = 5'h01,
		L_UP   = 5'h02,
		L_ON   = 5'h04,
		L_DOWN = 5'h08,
		L_HOLD = 5'h10
	} low_state_t;
endpackage

// file: verilog/rail_enable_and_switch_clock.sv
// Rail enable decoding, glitch filters, lockouts and switching clock.
// Assumes asynchronous pins, a 40 MHz clock and a plain register port.
//
// Overview of operation
// - Primary on, low supply good, low enable high: start low rails in order.
// - Off: all off; standby: bias; on: bias, primary, low rails per enable.
// - Low enable falling acts only after 300us low; host holds it so long.
// - Filtered low enable low: low rails off in shutdown order with delay.
// - After last low rail off, ignore low enable 200ms, rails stay off.
// - Second buck clock in phase; third buck in phase or inverted.
// - All bucks run from one shared 2.2MHz oscillator.
// - Spread code bits 2:0 at 0x7A; code zero means fixed frequency.
// - Spread picks among 32 frequencies within about 4 percent.
// - Codes 1 and 4 profiled slopes; codes 2,3,5,6,7 pseudo-random.
// - Code 2 dwells a random 1 to 8 switching cycles.
// - Code 3 dwells a random 4 to 32 cycles in steps of four.
// - Fixed dwells: code 1 3 or 6, codes 4..7 4, 4, 8, 24.
// - Linear rail rides through overcurrent unless 0x87 bit 2 asks hiccup.
// - Primary overvoltage tri-states switches; primary overcurrent hiccups.
// - Main enable drop acts only after 300us at the lower level.
// - Primary turns on only with bias above reset level and init done.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module rail_enable_and_switch_clock
	import rail_seq_pkg::*;
#(
	parameter int FILT_CYCLES   = FILT_CYC,
	parameter int LOCK_CYCLES   = LOCK_CYC,
	parameter int STEP_CYCLES   = SEQ_STEP_CYC,
	parameter int HICCUP_CYCLES = HICCUP_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Enable pins
	input  wire logic       en_standby_level,
	input  wire logic       en_on_level,
	input  wire logic       low_rail_enable_pin,
	// Analog status
	input  wire logic       low_rail_supply_ok,
	input  wire logic       bias_por_ok,
	input  wire logic       init_done,
	input  wire logic       linear_overcurrent,
	input  wire logic       primary_overcurrent,
	input  wire logic       primary_overvoltage,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Rail enables and primary tri-state
	output logic            bias_regulator_on,
	output logic            primary_buck_on,
	output logic            second_buck_on,
	output logic            third_buck_on,
	output logic            linear_rail_on,
	output logic            primary_tristate,
	// Switching clocks
	output logic            primary_clk,
	output logic            second_clk,
	output logic            third_clk
);
	import rail_seq_pkg::*;

	// ----------------------------------------------------------
	// Synchroniser
	// ----------------------------------------------------------
	logic [N_IN-1:0] s0, s1, s2, clean, next_clean, pins;
	assign pins = {primary_overvoltage, primary_overcurrent,
		linear_overcurrent, init_done, bias_por_ok, low_rail_supply_ok,
		low_rail_enable_pin, en_on_level, en_standby_level};
	always_comb begin
		next_clean = (s1 & s2) | (clean & (s1 | s2));
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s0    <= '0;
			s1    <= '0;
			s2    <= '0;
			clean <= '0;
		end else begin
			s0    <= pins;
			s1    <= s0;
			s2    <= s1;
			clean <= next_clean;
		end
	end

	// ----------------------------------------------------------
	// Falling-edge filters
	// ----------------------------------------------------------
	logic [1:0]       sync_lvl, mlvl, next_mlvl;
	logic [CNT_W-1:0] mcnt, next_mcnt, lfcnt, next_lfcnt;
	logic             lfilt, next_lfilt;
	always_comb begin
		sync_lvl = clean[IN_ON] ? LVL_ON :
			(clean[IN_STBY] ? LVL_STBY : LVL_OFF);
		next_mlvl  = mlvl;
		next_mcnt  = '0;
		next_lfilt = lfilt;
		next_lfcnt = '0;
		if (sync_lvl >= mlvl)
			next_mlvl = sync_lvl;
		else if (mcnt == CNT_W'(FILT_CYCLES - 1))
			next_mlvl = sync_lvl;
		else
			next_mcnt = mcnt + 1'b1;
		if (clean[IN_LOW])
			next_lfilt = 1'b1;
		else if (!lfilt || lfcnt == CNT_W'(FILT_CYCLES - 1))
			next_lfilt = 1'b0;
		else
			next_lfcnt = lfcnt + 1'b1;
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mlvl  <= LVL_OFF;
			mcnt  <= '0;
			lfilt <= 1'b0;
			lfcnt <= '0;
		end else begin
			mlvl  <= next_mlvl;
			mcnt  <= next_mcnt;
			lfilt <= next_lfilt;
			lfcnt <= next_lfcnt;
		end
	end

	// ----------------------------------------------------------
	// Registers
	// ----------------------------------------------------------
	logic [2:0] spread, next_spread;
	logic       lin_hic_en, next_lin_hic_en, phase, next_phase;
	logic [3:0] dly, next_dly;
	logic [7:0] next_rdata;
	logic [1:0] hic;
	always_comb begin
		next_spread     = spread;
		next_lin_hic_en = lin_hic_en;
		next_phase      = phase;
		next_dly        = dly;
		next_rdata      = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_SPREAD: next_spread = reg_wdata[2:0];
				ADDR_LIN: next_lin_hic_en = reg_wdata[LIN_HICCUP_BIT];
				ADDR_CTRL: begin
					next_phase = reg_wdata[CTRL_PHASE_BIT];
					next_dly   = reg_wdata[CTRL_DLY_LSB +: 4];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_SPREAD: next_rdata = {5'h00, spread};
				ADDR_LIN: next_rdata = 8'(lin_hic_en) << LIN_HICCUP_BIT;
				ADDR_CTRL: next_rdata = {dly, 3'h0, phase};
				ADDR_STATUS: next_rdata = {primary_tristate, |hic, lfilt,
					linear_rail_on, third_buck_on, second_buck_on,
					primary_buck_on, bias_regulator_on};
				default: next_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			spread     <= SPREAD_RST;
			lin_hic_en <= 1'b0;
			phase      <= 1'b0;
			dly        <= DLY_RST;
			reg_rdata  <= 8'h00;
		end else begin
			spread     <= next_spread;
			lin_hic_en <= next_lin_hic_en;
			phase      <= next_phase;
			dly        <= next_dly;
			reg_rdata  <= next_rdata;
		end
	end

	// ----------------------------------------------------------
	// Main enable and low rail sequencing
	// ----------------------------------------------------------
	main_state_t      mst, next_mst;
	low_state_t       lst, next_lst;
	logic [CNT_W-1:0] mtc, next_mtc, ltc, next_ltc, gap;
	logic [2:0]       lrails, next_lrails;
	logic             want, low_idle;
	always_comb begin
		gap = CNT_W'((32'(dly) + 1) * STEP_CYCLES - 1);
		want = mst == M_ON && lfilt && clean[IN_SUP];
		low_idle = lst == L_OFF || lst == L_HOLD;
		next_mst = mst;
		next_mtc = '0;
		unique case (mst)
			M_OFF: if (mlvl != LVL_OFF) next_mst = M_STBY;
			M_STBY: begin
				if (mlvl == LVL_OFF)
					next_mst = M_OFF;
				else if (mlvl == LVL_ON && clean[IN_POR] && clean[IN_INIT])
					next_mst = M_ON;
			end
			M_ON: if (mlvl != LVL_ON) next_mst = M_DOWN;
			M_DOWN: begin
				if (!low_idle)
					next_mst = M_DOWN;
				else if (mtc == gap)
					next_mst = M_HOLD;
				else
					next_mtc = mtc + 1'b1;
			end
			M_HOLD: begin
				if (mtc == CNT_W'(LOCK_CYCLES - 1))
					next_mst = mlvl == LVL_OFF ? M_OFF : M_STBY;
				else
					next_mtc = mtc + 1'b1;
			end
		endcase
		next_lst    = lst;
		next_ltc    = '0;
		next_lrails = lrails;
		unique case (lst)
			L_OFF: if (want) next_lst = L_UP;
			L_UP: begin
				if (!want)
					next_lst = L_DOWN;
				else if (ltc == gap) begin
					next_lrails = {lrails[1:0], 1'b1};
					if (lrails[1]) next_lst = L_ON;
				end else
					next_ltc = ltc + 1'b1;
			end
			L_ON: if (!want) next_lst = L_DOWN;
			L_DOWN: begin
				if (lrails == 3'h0)
					next_lst = L_OFF;
				else if (ltc == gap) begin
					next_lrails = lrails >> 1;
					if (!lrails[1]) next_lst = L_HOLD;
				end else
					next_ltc = ltc + 1'b1;
			end
			L_HOLD: begin
				if (ltc == CNT_W'(LOCK_CYCLES - 1))
					next_lst = L_OFF;
				else
					next_ltc = ltc + 1'b1;
			end
		endcase
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mst    <= M_OFF;
			mtc    <= '0;
			lst    <= L_OFF;
			ltc    <= '0;
			lrails <= 3'h0;
		end else begin
			mst    <= next_mst;
			mtc    <= next_mtc;
			lst    <= next_lst;
			ltc    <= next_ltc;
			lrails <= next_lrails;
		end
	end

	// ----------------------------------------------------------
	// Hiccup timers: 0 linear rail, 1 primary buck
	// ----------------------------------------------------------
	logic [1:0] trig;
	assign trig[0] = clean[IN_LOC] && lin_hic_en && lrails[2];
	assign trig[1] = clean[IN_POC] && (mst == M_ON || mst == M_DOWN);
	for (genvar i = 0; i < 2; i++) begin : g_hic
		logic [CNT_W-1:0] hc, next_hc;
		logic             next_act;
		always_comb begin
			next_act = hic[i];
			next_hc  = '0;
			if (hic[i]) begin
				if (hc == CNT_W'(HICCUP_CYCLES - 1))
					next_act = 1'b0;
				else
					next_hc = hc + 1'b1;
			end else if (trig[i])
				next_act = 1'b1;
		end
		always_ff @(posedge clk_sys or posedge sys_rst) begin
			if (sys_rst) begin
				hic[i] <= 1'b0;
				hc     <= '0;
			end else begin
				hic[i] <= next_act;
				hc     <= next_hc;
			end
		end
	end

	// ----------------------------------------------------------
	// Switching clock with spread spectrum
	// ----------------------------------------------------------
	logic [15:0] acc, next_acc, incr, lfsr, next_lfsr;
	logic [4:0]  fidx, next_fidx, dwell, next_dwell, dload;
	logic        carry, dir, next_dir;
	always_comb begin
		incr = 16'(NCO_BASE + 16'(fidx) * NCO_STEP);
		{carry, next_acc} = 17'(acc) + 17'(incr);
		next_lfsr  = lfsr;
		next_fidx  = fidx;
		next_dwell = dwell;
		next_dir   = dir;
		unique case (spread)
			SS_SLOPE: dload = dir ? DW_UP_M1 : DW_DN_M1;
			SS_RAND8: dload = {2'h0, lfsr[2:0]};
			SS_RAND32: dload = {lfsr[2:0], 2'h3};
			SS_TRI, SS_FIX4: dload = DW_4_M1;
			SS_FIX8: dload = DW_8_M1;
			SS_FIX24: dload = DW_24_M1;
			default: dload = 5'h00;
		endcase
		if (spread == SS_OFF) begin
			next_fidx  = FREQ_CENTER;
			next_dwell = 5'h00;
		end else if (carry) begin
			next_lfsr = (lfsr >> 1) ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
			if (dwell != 5'h00)
				next_dwell = dwell - 1'b1;
			else begin
				next_dwell = dload;
				if (spread == SS_SLOPE || spread == SS_TRI) begin
					if (dir && fidx == FREQ_MAX) begin
						next_dir  = 1'b0;
						next_fidx = fidx - 1'b1;
					end else if (!dir && fidx == 5'h00) begin
						next_dir  = 1'b1;
						next_fidx = fidx + 1'b1;
					end else
						next_fidx = dir ? fidx + 1'b1 : fidx - 1'b1;
				end else
					next_fidx = lfsr[4:0];
			end
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			acc   <= 16'h0000;
			lfsr  <= LFSR_SEED;
			fidx  <= FREQ_CENTER;
			dwell <= 5'h00;
			dir   <= 1'b1;
		end else begin
			acc   <= next_acc;
			lfsr  <= next_lfsr;
			fidx  <= next_fidx;
			dwell <= next_dwell;
			dir   <= next_dir;
		end
	end

	// ----------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------
	logic next_pri;
	always_comb begin
		next_pri = (mst == M_ON || mst == M_DOWN) && !hic[1];
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bias_regulator_on <= 1'b0;
			primary_buck_on   <= 1'b0;
			second_buck_on    <= 1'b0;
			third_buck_on     <= 1'b0;
			linear_rail_on    <= 1'b0;
			primary_tristate  <= 1'b0;
			primary_clk       <= 1'b0;
			second_clk        <= 1'b0;
			third_clk         <= 1'b0;
		end else begin
			bias_regulator_on <= mst != M_OFF;
			primary_buck_on   <= next_pri;
			second_buck_on    <= lrails[0];
			third_buck_on     <= lrails[1];
			linear_rail_on    <= lrails[2] && !hic[0];
			primary_tristate  <= next_pri && clean[IN_POV];
			primary_clk       <= next_acc[15];
			second_clk        <= next_acc[15];
			third_clk         <= next_acc[15] ^ phase;
		end
	end

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_standby_rails: assert property (mst == M_STBY |=>
		bias_regulator_on && !primary_buck_on && !second_buck_on)
		else $error("standby rails wrong");
	a_low_start: assert property (lst == L_OFF && want |=>
		lst == L_UP) else $error("low rails did not start");
	a_low_filter: assert property ($fell(lfilt) |->
		$past(lfcnt) == CNT_W'(FILT_CYCLES - 1))
		else $error("low enable fell early");
	a_low_shut: assert property (lst == L_ON && !want |=>
		lst == L_DOWN) else $error("low rails not shutting");
	a_low_hold: assert property (lst == L_HOLD |=>
		!second_buck_on && !third_buck_on && !linear_rail_on)
		else $error("low rail on in lockout");
	a_clk_phase: assert property (second_clk == primary_clk &&
		third_clk == (primary_clk ^ $past(phase)))
		else $error("buck clock phase wrong");
	a_spread_off: assert property (spread == SS_OFF |=>
		fidx == FREQ_CENTER) else $error("spread not off");
	a_incr_span: assert property (incr >= NCO_BASE &&
		incr <= NCO_TOP) else $error("frequency out of span");
	a_dwell_rand: assert property (carry && dwell == 5'h00 &&
		spread == SS_RAND8 |=> dwell <= DW_8_M1)
		else $error("dwell above eight");
	a_dwell_quad: assert property (carry && dwell == 5'h00 &&
		spread == SS_RAND32 |=> dwell[1:0] == 2'h3)
		else $error("dwell not multiple of four");
	a_dwell_fix: assert property (carry && dwell == 5'h00 &&
		spread == SS_FIX24 |=> dwell == DW_24_M1)
		else $error("fixed dwell wrong");
	a_lin_hiccup: assert property ($rose(hic[0]) |->
		$past(lin_hic_en)) else $error("hiccup while disabled");
	a_pri_tristate: assert property (next_pri && clean[IN_POV] |=>
		primary_tristate) else $error("no tri-state on overvoltage");
	a_main_filter: assert property (mlvl < $past(mlvl) |->
		$past(mcnt) == CNT_W'(FILT_CYCLES - 1))
		else $error("main enable fell early");
	a_pri_entry: assert property ($rose(mst == M_ON) |->
		$past(clean[IN_POR] && clean[IN_INIT]))
		else $error("primary on without init");
	a_filt_restart: assert property (clean[IN_LOW] |=>
		lfcnt == '0 && lfilt) else $error("filter not restarted");
	c_full_on: cover property (mst == M_ON && lst == L_ON);
	c_low_hold: cover property (lst == L_HOLD);
	c_main_hold: cover property (mst == M_HOLD);
	c_tri_turn: cover property (spread == SS_TRI && carry && !dir);
endmodule

// file: tb/enable_host.sv
// Host model that drives the enable pins of the rail sequencer.
// Assumes it is called just after a rising edge of the shared clock.
`timescale 1ns/1ps
module enable_host #(
	parameter int FILT_CYCLES = 20
) (
	// Clock
	input  wire logic clk_sys,
	// Enable pins and low rail supply status
	output logic      en_standby_level,
	output logic      en_on_level,
	output logic      low_rail_enable_pin,
	output logic      low_rail_supply_ok
);
	int cur_lvl;

	initial begin
		cur_lvl = 0;
		en_standby_level = 1'b0;
		en_on_level = 1'b0;
		low_rail_enable_pin = 1'b0;
		low_rail_supply_ok = 1'b1;
	end

	// ----------------------------------------------------------
	// Level changes, drops held past the filter
	// ----------------------------------------------------------
	task automatic set_main(input int lvl);
		en_standby_level <= (lvl != 0);
		en_on_level      <= (lvl == 2);
		if (lvl < cur_lvl)
			repeat (FILT_CYCLES + 8) @(posedge clk_sys);
		cur_lvl = lvl;
	endtask

	task automatic set_supply(input logic v);
		low_rail_supply_ok <= v;
	endtask

	task automatic set_low(input logic v);
		low_rail_enable_pin <= v;
		if (!v)
			repeat (FILT_CYCLES + 8) @(posedge clk_sys);
	endtask

	// Short drop on purpose; both pins are high around it
	task automatic glitch(input bit on_main, input int len);
		en_on_level         <= !on_main;
		low_rail_enable_pin <= on_main;
		repeat (len) @(posedge clk_sys);
		en_on_level         <= 1'b1;
		low_rail_enable_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// file: tb/rail_enable_and_switch_clock_test.sv
// Self-checking bench of the rail enable and switching clock block.
// Assumes shortened filter, lock, step and hiccup counts.
`timescale 1ns/1ps
module rail_enable_and_switch_clock_test;
	import rail_seq_pkg::*;
	localparam int FC = 20;
	localparam int LC = 50;
	localparam int SC = 4;
	localparam int HC = 30;

	logic       clk_sys;
	logic       sys_rst;
	logic       bias_por_ok;
	logic       init_done;
	logic       linear_overcurrent;
	logic       primary_overcurrent;
	logic       primary_overvoltage;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	wire  [7:0] reg_rdata;
	wire        en_standby_level;
	wire        en_on_level;
	wire        low_rail_enable_pin;
	wire        low_rail_supply_ok;
	wire  [5:0] rails;
	wire  [2:0] clks;
	logic [7:0] shadow [256];
	int         num_errors = 0;
	int         checks_done = 0;
	int         cyc = 0;

	// ----------------------------------------------------------
	// Instances
	// ----------------------------------------------------------
	enable_host #(.FILT_CYCLES(FC)) host_u (
		.clk_sys            (clk_sys),
		.en_standby_level   (en_standby_level),
		.en_on_level        (en_on_level),
		.low_rail_enable_pin(low_rail_enable_pin),
		.low_rail_supply_ok (low_rail_supply_ok)
	);

	rail_enable_and_switch_clock #(.FILT_CYCLES(FC), .LOCK_CYCLES(LC),
		.STEP_CYCLES(SC), .HICCUP_CYCLES(HC)) dut_u (
		.clk_sys(clk_sys), .sys_rst(sys_rst),
		.en_standby_level(en_standby_level), .en_on_level(en_on_level),
		.low_rail_enable_pin(low_rail_enable_pin),
		.low_rail_supply_ok(low_rail_supply_ok),
		.bias_por_ok(bias_por_ok), .init_done(init_done),
		.linear_overcurrent(linear_overcurrent),
		.primary_overcurrent(primary_overcurrent),
		.primary_overvoltage(primary_overvoltage),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bias_regulator_on(rails[0]), .primary_buck_on(rails[1]),
		.second_buck_on(rails[2]), .third_buck_on(rails[3]),
		.linear_rail_on(rails[4]), .primary_tristate(rails[5]),
		.primary_clk(clks[0]), .second_clk(clks[1]), .third_clk(clks[2])
	);

	// ----------------------------------------------------------
	// Clock, timeout, model and checks
	// ----------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = !clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// Expected {linear, third, second, primary, bias}
	function automatic logic [4:0] model_rails(int lvl, bit low);
		if (lvl == 0)
			return 5'h00;
		if (lvl == 1)
			return 5'h01;
		return low ? 5'h1F : 5'h03;
	endfunction

	function automatic logic [7:0] mask_of(logic [7:0] a);
		case (a)
			ADDR_SPREAD: return 8'h07;
			ADDR_LIN: return 8'h04;
			ADDR_CTRL: return 8'hF1;
			default: return 8'hFF;
		endcase
	endfunction

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		if (mask_of(a) != 8'hFF)
			shadow[a] = d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [7:0] a);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		check("register", reg_rdata & mask_of(a), shadow[a] & mask_of(a));
	endtask

	task automatic wait_bit(input string what, input int i, input logic v,
		input int lim, output int n);
		n = 0;
		while (rails[i] !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		check(what, rails[i], v);
	endtask

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		int unsigned seed;
		int d, g, n, lo, hi, per, ph;
		logic prev;
		foreach (shadow[i])
			shadow[i] = 8'h00;
		sys_rst = 1'b1;
		bias_por_ok = 1'b0;
		init_done = 1'b0;
		linear_overcurrent = 1'b0;
		primary_overcurrent = 1'b0;
		primary_overvoltage = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		seed = $urandom(32'h321754d3);
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		check("rails at reset", rails, 6'h00);
		rd_chk(ADDR_SPREAD);
		rd_chk(ADDR_LIN);
		wr(8'h5A, 8'hFF);
		rd_chk(8'h5A);
		$display("test reset done");

		bias_por_ok <= 1'b1;
		host_u.set_main(2);
		repeat (30) @(posedge clk_sys);
		check("primary before init", rails[1], 1'b0);
		bias_por_ok <= 1'b0;
		init_done   <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check("primary before bias", rails[1], 1'b0);
		bias_por_ok <= 1'b1;
		wait_bit("primary on", 1, 1'b1, 20, n);
		check("rails main on", rails[4:0], model_rails(2, 0));
		$display("test main on done");

		d = $urandom_range(3, 0);
		g = (d + 1) * SC;
		wr(ADDR_CTRL, {d[3:0], 4'h0});
		rd_chk(ADDR_CTRL);
		host_u.set_supply(1'b0);
		host_u.set_low(1'b1);
		repeat (FC) @(posedge clk_sys);
		check("low rails without supply", rails[2], 1'b0);
		host_u.set_supply(1'b1);
		wait_bit("second on", 2, 1'b1, g + 20, n);
		check("third after second", rails[3], 1'b0);
		wait_bit("third on", 3, 1'b1, g + 4, n);
		check("startup gap", n >= g - 1 && n <= g + 1, 1'b1);
		wait_bit("linear on", 4, 1'b1, g + 4, n);
		check("rails all on", rails[4:0], model_rails(2, 1));
		shadow[ADDR_STATUS] = 8'h3F;
		rd_chk(ADDR_STATUS);
		repeat (2) host_u.glitch(0, $urandom_range(FC - 6, 2));
		repeat (FC + 10) @(posedge clk_sys);
		check("rails after glitch", rails[4:0], 5'h1F);
		$display("test low start done");

		host_u.set_low(1'b0);
		wait_bit("linear off", 4, 1'b0, g + 20, n);
		check("second at linear off", rails[2], 1'b1);
		wait_bit("third off", 3, 1'b0, g + 4, n);
		wait_bit("second off", 2, 1'b0, g + 4, n);
		host_u.set_low(1'b1);
		repeat (LC - 10) @(posedge clk_sys);
		check("rails in lockout", rails[4:0], 5'h03);
		wait_bit("second restart", 2, 1'b1, 3 * g + 40, n);
		wait_bit("linear restart", 4, 1'b1, 2 * g + 8, n);
		$display("test low stop done");

		linear_overcurrent <= 1'b1;
		repeat (8) @(posedge clk_sys);
		linear_overcurrent <= 1'b0;
		repeat (10) @(posedge clk_sys);
		check("linear rides through", rails[4], 1'b1);
		wr(ADDR_LIN, 8'h04);
		rd_chk(ADDR_LIN);
		linear_overcurrent <= 1'b1;
		repeat (8) @(posedge clk_sys);
		linear_overcurrent <= 1'b0;
		wait_bit("linear hiccup off", 4, 1'b0, 10, n);
		wait_bit("linear retry", 4, 1'b1, HC + 40, n);
		primary_overcurrent <= 1'b1;
		repeat (6) @(posedge clk_sys);
		primary_overcurrent <= 1'b0;
		wait_bit("primary hiccup off", 1, 1'b0, 10, n);
		wait_bit("primary retry", 1, 1'b1, HC + 40, n);
		primary_overvoltage <= 1'b1;
		wait_bit("tristate on", 5, 1'b1, 10, n);
		check("primary under tristate", rails[1], 1'b1);
		primary_overvoltage <= 1'b0;
		wait_bit("tristate off", 5, 1'b0, 10, n);
		$display("test faults done");

		for (int code = 0; code < 8; code++) begin
			ph = code % 2;
			wr(ADDR_SPREAD, 8'(code));
			rd_chk(ADDR_SPREAD);
			wr(ADDR_CTRL, {d[3:0], 3'h0, ph[0]});
			repeat (4) @(posedge clk_sys);
			lo = 99;
			hi = 0;
			per = -200;
			prev = clks[0];
			repeat (800) begin
				@(posedge clk_sys);
				check("second clk", clks[1], clks[0]);
				check("third clk", clks[2], clks[0] ^ ph[0]);
				per++;
				if (clks[0] && !prev) begin
					if (per > 0) begin
						lo = (per < lo) ? per : lo;
						hi = (per > hi) ? per : hi;
					end
					per = 0;
				end
				prev = clks[0];
			end
			if (code == 0)
				check("fixed period", lo >= 18 && hi <= 19, 1'b1);
			else
				check("spread period", lo >= 17 && hi <= 20, 1'b1);
		end
		$display("test clocks done");

		host_u.glitch(1, $urandom_range(FC - 6, 2));
		repeat (FC + 10) @(posedge clk_sys);
		check("primary after glitch", rails[1], 1'b1);
		host_u.set_main(1);
		wait_bit("primary off", 1, 1'b0, 5 * g + 40, n);
		check("low rails first", rails[4:2], 3'h0);
		repeat (LC + 20) @(posedge clk_sys);
		check("rails standby", rails[4:0], model_rails(1, 1));
		host_u.set_main(0);
		wait_bit("bias off", 0, 1'b0, 20, n);
		check("rails shutdown", rails[4:0], model_rails(0, 1));
		$display("test main drop done");
		tally_and_finish();
	end
endmodule
